// [rtl/ics_regs.svh]
// Register offsets, field positions, reset values and writable masks for the two-wire controller.
// Behaviour
// - The fourteen byte registers sit at indices 0xFC00 to 0xFC11, with status directly after control.
// - After reset the divider reads 0x03, setup time 0x01, hardware status zero 0xC0, time base 0xFF, all others zero.
// - Control bit 7 switches the two-wire interface on when set and off when clear, and resets to zero.
// - Control bits 6 down to 1 each enable the interrupt of one of the six status flags, numbered zero to five.
// - Control bit 0 decides whether the slave answers the general call address.
// - Status bit 7 is a read-only busy indication, set by a start condition and cleared by a stop condition.
// - Status bit 6 is set at acknowledge time of a received address matching our own and is cleared by writing one.
// - Status bit 5 is set when an acknowledge or not-acknowledge follows our address and command byte, cleared by one.
// - The reception-complete flag is set once a received byte is complete, before its acknowledge is sent.
// - The SMBus flag is the OR of the SMBus interrupt status register and clears only once its sources clear.
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define ICS_IDX_CTRL 16'hFC00
`define ICS_IDX_STAT 16'hFC01
`define ICS_IDX_RXD 16'hFC02
`define ICS_IDX_TXD 16'hFC03
`define ICS_IDX_TSA 16'hFC04
`define ICS_IDX_OWN 16'hFC05
`define ICS_IDX_DIV 16'hFC06
`define ICS_IDX_CMD 16'hFC07
`define ICS_IDX_SETUP 16'hFC08
`define ICS_IDX_HOLD 16'hFC09
`define ICS_IDX_HW0 16'hFC0A
`define ICS_IDX_HW1 16'hFC0B
`define ICS_IDX_TBASE 16'hFC10
`define ICS_IDX_SMB 16'hFC11

// Reset values of the registers that do not start at zero.
`define ICS_RST_DIV 8'h03
`define ICS_RST_SETUP 8'h01
`define ICS_RST_HW0 8'hC0
`define ICS_RST_TBASE 8'hFF

// Writable bit masks; other bits are reserved and read as zero.
`define ICS_WM_DIV 8'h03
`define ICS_WM_CMD 8'h1F
`define ICS_WM_SETUP 8'h3F
`define ICS_WM_HOLD 8'h9F

// Field positions.
`define ICS_CTRL_ON 7
`define ICS_CTRL_GCA 0
`define ICS_STAT_BUSY 7
`define ICS_STAT_RXACK 0
`define ICS_CMD_END 1
`define ICS_CMD_GO 0
`define ICS_NFLAG 6

`endif

// [rtl/ics_pkg.sv]
// Types shared by the two-wire controller register block.
`default_nettype none
package ics_pkg;

  // Bus slave handshake states, one-hot.
  typedef enum logic [1:0] {
    ICS_IDLE = 2'b01,
    ICS_ACK = 2'b10
  } ics_bus_state_type;

  // Events reported by the serial engine; the event bits are one-cycle pulses, hw0 and hw1 are status levels.
  typedef struct packed {
    logic start_det;
    logic stop_det;
    logic addr_rcvd;
    logic [7:0] rx_addr;
    logic addr_ack_rx;
    logic data_ack_rx;
    logic rx_done;
    logic [7:0] rx_byte;
    logic ack_bit;
    logic [7:0] smb_set;
    logic [7:0] hw0;
    logic [7:0] hw1;
  } ics_event_type;

  // Configuration handed to the serial engine.
  typedef struct packed {
    logic interface_on;
    logic general_call_reply_en;
    logic addr_reply;
    logic [7:0] tx_byte;
    logic [7:0] target_addr;
    logic [7:0] scl_div;
    logic [7:0] command;
    logic [7:0] setup_time;
    logic [7:0] hold_time;
    logic [7:0] time_base;
  } ics_config_type;

endpackage : ics_pkg
`default_nettype wire

// [rtl/ics_ctrl.sv]
// Control and status registers of the two-wire serial controller behind an Avalon-MM slave.
`default_nettype none
`include "ics_regs.svh"

module ics_ctrl
  import ics_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ics_event_type evt,
  output ics_config_type cfg,
  output logic irq
);

  // Register storage.
  ics_bus_state_type state_r;
  ics_bus_state_type state_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic [7:0] ctrl_r;
  logic busy_r;
  logic rxack_r;
  logic [`ICS_NFLAG-1:0] flag_r;
  logic [7:0] rxd_r;
  logic [7:0] txd_r;
  logic [7:0] tsa_r;
  logic [7:0] own_r;
  logic [7:0] div_r;
  logic [7:0] cmd_r;
  logic [7:0] setup_r;
  logic [7:0] hold_r;
  logic [7:0] hw0_r;
  logic [7:0] hw1_r;
  logic [7:0] tbase_r;
  logic [7:0] smb_r;
  logic reply_r;

  // Address decode on the word index.
  wire [15:0] idx = avs_address[17:2];
  wire hit_ctrl = (idx == `ICS_IDX_CTRL);
  wire hit_stat = (idx == `ICS_IDX_STAT);
  wire hit_rxd = (idx == `ICS_IDX_RXD);
  wire hit_txd = (idx == `ICS_IDX_TXD);
  wire hit_tsa = (idx == `ICS_IDX_TSA);
  wire hit_own = (idx == `ICS_IDX_OWN);
  wire hit_div = (idx == `ICS_IDX_DIV);
  wire hit_cmd = (idx == `ICS_IDX_CMD);
  wire hit_setup = (idx == `ICS_IDX_SETUP);
  wire hit_hold = (idx == `ICS_IDX_HOLD);
  wire hit_hw0 = (idx == `ICS_IDX_HW0);
  wire hit_hw1 = (idx == `ICS_IDX_HW1);
  wire hit_tbase = (idx == `ICS_IDX_TBASE);
  wire hit_smb = (idx == `ICS_IDX_SMB);

  // A request is taken in the cycle the slave drops waitrequest.
  wire taken = (state_r == ICS_ACK);
  wire wr_go = taken & avs_write & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];

  // Interface enable and general call reply enable.
  wire on = ctrl_r[`ICS_CTRL_ON];
  wire gca_en = ctrl_r[`ICS_CTRL_GCA];
  wire [`ICS_NFLAG-1:0] en = ctrl_r[6:1];

  // Own address match, including the general call address when replies are enabled.
  wire own_hit = (evt.rx_addr[7:1] == own_r[7:1]);
  wire gc_hit = (evt.rx_addr[7:1] == 7'h00) & gca_en;
  wire match = on & evt.addr_rcvd & (own_hit | gc_hit);

  // Event sources, indexed by status bit minus one; the SMBus flag at index 1 is a level.
  wire [`ICS_NFLAG-1:0] ev_set;
  assign ev_set[5] = match;
  assign ev_set[4] = on & evt.addr_ack_rx;
  assign ev_set[3] = on & evt.data_ack_rx;
  assign ev_set[2] = on & evt.rx_done;
  assign ev_set[1] = 1'b0;
  assign ev_set[0] = on & evt.stop_det;

  // Write-one-to-clear strobes; flag i lives at status bit i+1, next to its enable at control bit i+1.
  wire [`ICS_NFLAG-1:0] ev_clr = (wr_go & hit_stat) ? wd[6:1] : '0;

  // SMBus status: hardware set wins over a software clear.
  wire [7:0] smb_clr = (wr_go & hit_smb) ? wd : 8'h00;
  wire [7:0] smb_nxt = (smb_r & ~smb_clr) | (on ? evt.smb_set : 8'h00);

  // Per-flag sticky logic.
  wire [`ICS_NFLAG-1:0] flag_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < `ICS_NFLAG; gi++) begin : g_flag
      if (gi == 1) begin : g_lvl
        assign flag_nxt[gi] = |smb_nxt;
      end else begin : g_sticky
        assign flag_nxt[gi] = (flag_r[gi] & ~ev_clr[gi]) | ev_set[gi];
      end
    end
  endgenerate

  // Flags placed into the status byte with busy and the acknowledge bit.
  wire [7:0] stat_view = {busy_r, flag_r, rxack_r};

  // Busy follows start and stop conditions; a stop in the same cycle frees the bus.
  wire busy_nxt = evt.stop_det ? 1'b0 : (evt.start_det ? 1'b1 : busy_r);

  // Command register: software sets bits, hardware clears them when done or when disabled.
  wire [7:0] cmd_wr = (wr_go & hit_cmd) ? (wd & `ICS_WM_CMD) : cmd_r;
  wire [7:0] cmd_done = {6'h00, evt.stop_det, evt.start_det};
  wire [7:0] cmd_nxt = on ? (cmd_wr & ~cmd_done) : 8'h00;

  // Interrupt when any enabled flag is set.
  wire irq_nxt = |(flag_nxt & en);

  // Read selection.
  wire [7:0] rsel =
    hit_ctrl ? ctrl_r :
    hit_stat ? stat_view :
    hit_rxd ? rxd_r :
    hit_txd ? txd_r :
    hit_tsa ? tsa_r :
    hit_own ? own_r :
    hit_div ? div_r :
    hit_cmd ? cmd_r :
    hit_setup ? setup_r :
    hit_hold ? hold_r :
    hit_hw0 ? hw0_r :
    hit_hw1 ? hw1_r :
    hit_tbase ? tbase_r :
    hit_smb ? smb_r : 8'h00;

  // Bus handshake: one wait cycle, then a single answer cycle.
  always_comb begin
    case (state_r)
      ICS_IDLE: state_nxt = (avs_read | avs_write) ? ICS_ACK : ICS_IDLE;
      ICS_ACK: state_nxt = ICS_IDLE;
      default: state_nxt = ICS_IDLE;
    endcase
  end

  // Handshake state, waitrequest and read data.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ICS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      wait_r <= (state_nxt != ICS_ACK);
      rdata_r <= {24'h000000, rsel};
    end
  end

  // Control register.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= 8'h00;
    end else if (wr_go & hit_ctrl) begin
      ctrl_r <= wd;
    end
  end

  // Status flags, busy and acknowledge bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= '0;
      busy_r <= 1'b0;
      rxack_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      busy_r <= busy_nxt;
      rxack_r <= (evt.addr_ack_rx | evt.data_ack_rx) ? evt.ack_bit : rxack_r;
      irq_r <= irq_nxt;
    end
  end

  // Received data and received command bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_r <= 8'h00;
      own_r <= 8'h00;
      reply_r <= 1'b0;
    end else begin
      rxd_r <= evt.rx_done ? evt.rx_byte : rxd_r;
      own_r[7:1] <= (wr_go & hit_own) ? wd[7:1] : own_r[7:1];
      own_r[0] <= match ? evt.rx_addr[0] : own_r[0];
      reply_r <= evt.addr_rcvd ? match : reply_r;
    end
  end

  // Software-written configuration.
  always_ff @(posedge clk) begin
    if (rst) begin
      txd_r <= 8'h00;
      tsa_r <= 8'h00;
      div_r <= `ICS_RST_DIV;
      setup_r <= `ICS_RST_SETUP;
      hold_r <= 8'h00;
      tbase_r <= `ICS_RST_TBASE;
    end else if (wr_go) begin
      txd_r <= hit_txd ? wd : txd_r;
      tsa_r <= hit_tsa ? wd : tsa_r;
      div_r <= hit_div ? (wd & `ICS_WM_DIV) : div_r;
      setup_r <= hit_setup ? (wd & `ICS_WM_SETUP) : setup_r;
      hold_r <= hit_hold ? (wd & `ICS_WM_HOLD) : hold_r;
      tbase_r <= hit_tbase ? wd : tbase_r;
    end
  end

  // Command, SMBus status and hardware status mirrors.
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_r <= 8'h00;
      smb_r <= 8'h00;
      hw0_r <= `ICS_RST_HW0;
      hw1_r <= 8'h00;
    end else begin
      cmd_r <= cmd_nxt;
      smb_r <= smb_nxt;
      hw0_r <= evt.hw0;
      hw1_r <= evt.hw1;
    end
  end

  // Outputs, all taken straight from registers.
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign irq = irq_r;
  // The whole configuration bundle is driven by one assignment so that it has a single driver.
  assign cfg = '{interface_on: on, general_call_reply_en: gca_en, addr_reply: reply_r, tx_byte: txd_r,
    target_addr: tsa_r, scl_div: div_r, command: cmd_r, setup_time: setup_r, hold_time: hold_r,
    time_base: tbase_r};

endmodule : ics_ctrl
`default_nettype wire

// [test/ics_ctrl_properties.sv]
// Concurrent checks on the ports of the two-wire controller register block.
`default_nettype none
module ics_ctrl_checker
  import ics_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire ics_event_type evt,
  input wire ics_config_type cfg,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // An accepted write, the word index and any flag-raising event.
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [15:0] idx = avs_address[17:2];
  wire ev = evt.addr_rcvd | evt.addr_ack_rx | evt.data_ack_rx | evt.rx_done | evt.stop_det | (|evt.smb_set);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer cycle too long");
  answer_time_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  reset_vals_a: assert property ($fell(rst) |-> cfg.scl_div == 8'h03 && cfg.setup_time == 8'h01
    && cfg.time_base == 8'hFF && !cfg.interface_on) else $error("bad reset value");
  enable_write_a: assert property ($rose(cfg.interface_on) |-> $past(wr_ok && idx == 16'hFC00 && avs_writedata[7]))
    else $error("enable without write");
  gca_write_a: assert property ($changed(cfg.general_call_reply_en) |-> $past(wr_ok && idx == 16'hFC00))
    else $error("reply enable changed alone");
  tx_write_a: assert property ($changed(cfg.tx_byte) |-> $past(wr_ok && idx == 16'hFC03))
    else $error("transmit byte changed alone");
  irq_cause_a: assert property ($rose(irq) |-> $past(ev) || $past(wr_ok, 2))
    else $error("interrupt without cause");
  irq_clear_a: assert property ($fell(irq) |-> $past(wr_ok) || $past(wr_ok, 2))
    else $error("interrupt dropped without write");
endmodule : ics_ctrl_checker
bind ics_ctrl ics_ctrl_checker ics_ctrl_checker_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt), .cfg(cfg), .irq(irq));
`default_nettype wire

// [test/ics_far_end.sv]
// Behavioural far side of the two-wire bus that turns a request code into event pulses.
`default_nettype none
module ics_far_end
  import ics_pkg::*;
(
  input wire logic [2:0] kind,
  input wire logic [7:0] dat,
  output ics_event_type evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each code is held one clock, so every bus happening is a single pulse.
  always_comb begin
    evt = '0;
    evt.hw0 = 8'hC0;
    evt.rx_addr = dat;
    evt.rx_byte = dat;
    case (kind)
      3'h1: evt.start_det = 1'b1;
      3'h2: evt.stop_det = 1'b1;
      3'h3: evt.addr_rcvd = 1'b1;
      3'h4: evt.addr_ack_rx = 1'b1;
      3'h5: evt.rx_done = 1'b1;
      3'h6: evt.smb_set = dat;
      3'h7: begin
        evt.data_ack_rx = 1'b1;
        evt.ack_bit = dat[0];
      end
      default: evt.hw1 = 8'h00;
    endcase
  end
endmodule : ics_far_end
`default_nettype wire

// [test/ics_ctrl_bench.sv]
// Self-checking bench for the two-wire controller register block.
`default_nettype none
module ics_ctrl_bench
  import ics_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [2:0] kind = '0;
  logic [7:0] dat = '0;
  logic [7:0] q;
  ics_event_type evt;
  ics_config_type cfg;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  ics_ctrl ics_ctrl_inst (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt(evt), .cfg(cfg), .irq(irq));
  ics_far_end ics_far_end_inst (.kind(kind), .dat(dat), .evt(evt));
  // Clock at 100 ns and a cycle limit that cuts a hang short.
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One bus access held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {ix, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) chk(8'h00, 8'h01);
  endtask : bus
  task automatic rd(input logic [15:0] ix, input logic [7:0] e);
    bus(1'b0, ix, 8'h00);
    chk(q, e);
  endtask : rd
  task automatic pulse(input logic [2:0] k, input logic [7:0] d);
    @(posedge clk);
    kind <= k;
    dat <= d;
    @(posedge clk);
    kind <= 3'h0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic t_regs();
    logic [15:0] ix [15] = '{16'hFC00, 16'hFC01, 16'hFC02, 16'hFC03, 16'hFC04, 16'hFC05, 16'hFC06, 16'hFC07,
      16'hFC08, 16'hFC09, 16'hFC0A, 16'hFC0B, 16'hFC10, 16'hFC11, 16'hFC0C};
    logic [7:0] rv [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'hC0,
      8'h00, 8'hFF, 8'h00, 8'h00};
    logic [7:0] wv [15] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFE, 8'h03, 8'h1F, 8'h3F, 8'h9F, 8'hC0,
      8'h00, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 15; i++) begin
      rd(ix[i], rv[i]);
      bus(1'b1, ix[i], 8'hFF);
      rd(ix[i], wv[i]);
    end
    chk({7'h00, cfg.interface_on}, 8'h01);
    chk({7'h00, cfg.general_call_reply_en}, 8'h01);
    chk(cfg.scl_div, 8'h03);
    chk(cfg.time_base, 8'hFF);
    chk(cfg.tx_byte, 8'hFF);
    chk(cfg.target_addr, 8'hFF);
    chk(cfg.setup_time, 8'h3F);
    chk(cfg.hold_time, 8'h9F);
    chk(cfg.command, 8'h1F);
    $display("register map done");
  endtask : t_regs
  task automatic t_busy();
    pulse(3'h1, 8'h00);
    rd(16'hFC01, 8'h80);
    pulse(3'h2, 8'h00);
    rd(16'hFC01, 8'h02);
    bus(1'b1, 16'hFC01, 8'h02);
    rd(16'hFC01, 8'h00);
    $display("busy done");
  endtask : t_busy
  task automatic t_flags();
    pulse(3'h3, 8'hFF);
    rd(16'hFC01, 8'h40);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, cfg.addr_reply}, 8'h01);
    bus(1'b1, 16'hFC01, 8'h00);
    rd(16'hFC01, 8'h40);
    bus(1'b1, 16'hFC01, 8'h40);
    rd(16'hFC01, 8'h00);
    pulse(3'h7, 8'h01);
    rd(16'hFC01, 8'h11);
    bus(1'b1, 16'hFC01, 8'h10);
    rd(16'hFC01, 8'h01);
    pulse(3'h4, 8'h00);
    rd(16'hFC01, 8'h20);
    bus(1'b1, 16'hFC01, 8'h20);
    pulse(3'h5, 8'h3C);
    rd(16'hFC01, 8'h08);
    rd(16'hFC02, 8'h3C);
    bus(1'b1, 16'hFC01, 8'h08);
    pulse(3'h6, 8'h04);
    bus(1'b1, 16'hFC01, 8'h04);
    rd(16'hFC01, 8'h04);
    bus(1'b1, 16'hFC11, 8'h04);
    rd(16'hFC01, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("flags done");
  endtask : t_flags
  task automatic t_mask();
    bus(1'b1, 16'hFC00, 8'h80);
    pulse(3'h5, 8'h11);
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, 16'hFC00, 8'h88);
    rd(16'hFC01, 8'h08);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, 16'hFC01, 8'h08);
    bus(1'b1, 16'hFC00, 8'h00);
    pulse(3'h5, 8'h22);
    rd(16'hFC01, 8'h00);
    $display("mask done");
  endtask : t_mask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Reset for eight clocks, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_busy();
    t_flags();
    t_mask();
    tally_and_finish();
  end
endmodule : ics_ctrl_bench
`default_nettype wire
